// ===== design/iocs_pkg.sv
// Functional notes
// - Trim is 5-bit two's complement, reset zero.
// - Trim change slews fast oscillator, no completion flag.
// - Trim never touches the slow oscillator.
// - 01111 max, 00000 calibrated, 10000 min.
// - Trim bits 7-5 read zero, writes ignored.
// - Slow oscillator 31 kHz, timers' time base.
// - Slow oscillator enable conditions include select 000.
// - Slow-oscillator-stable status bit provided.
// - Select picks one of eight internal frequencies.
// - Reset loads select 110, 4 MHz.
// - Switch: start, wait, fall edge, hold low, connect.
// - No start-up delay between fast postscaler taps.
// - Two-cycle sync of new clock after start-up.
// - Slow osc off after switch to fast unless power-up timer/watchdog/monitor.
// - Select bit 0 configured source, 1 internal.
// - Reset clears system clock select bit.
// - Automatic switches never modify clock select bit.
// - External-ready flag reports external source running.
// - Fast-oscillator-stable status bit provided.
// - Fast osc enabled: select nonzero and internal or two-speed, or active or pending select nonzero.
package iocs_pkg;
  localparam logic [3:0] ADDR_TRIM = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [4:0] TRIM_RESET = 5'h00;
  localparam logic [2:0] FSEL_RESET = 3'h6;
  localparam logic [2:0] FSEL_SLOW = 3'h0;
  localparam int CTRL_FSEL_LSB = 4;
  localparam int CTRL_EXT_BIT = 3;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_SLOW_BIT = 1;
  localparam int CTRL_SCS_BIT = 0;
  localparam int CLK_MHZ = 200;
  localparam int FAST_START_NS = 1000;
  localparam int FAST_START_CYC = (FAST_START_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_START_NS = 2000;
  localparam int SLOW_START_CYC = (SLOW_START_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 2;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iocs_bus_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_SYNC,
    ST_SWAP
  } iocs_state_type;
endpackage

// ===== design/iocs_clock_select.sv
`timescale 1ns/1ps
module iocs_clock_select (
  input wire logic clk,
  input wire logic rst_n,
  input iocs_pkg::iocs_bus_type bus,
  output logic [7:0] rdata,
  input wire logic fast_clk_tick,
  input wire logic slow_clk_tick,
  input wire logic ext_clk_tick,
  input wire logic two_speed_enable,
  input wire logic ext_crystal_mode,
  input wire logic osc_startup_done,
  input wire logic power_up_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic clock_fail_monitor_en,
  input wire logic clock_fail_active,
  output logic [4:0] trim_value,
  output logic fast_osc_enable,
  output logic slow_osc_enable,
  output logic [2:0] active_freq_select,
  output logic use_internal,
  output logic sys_clk_gate_low,
  output logic divided_clock_output
);
  import iocs_pkg::*;
  logic [1:0] fast_sync_reg, slow_sync_reg, ext_sync_reg, ostd_sync_reg, fail_sync_reg;
  logic [4:0] trim_reg;
  logic [2:0] fsel_reg, active_reg;
  logic scs_reg, fast_en_reg, slow_en_reg, fast_ok_reg, slow_ok_reg, ext_ready_reg;
  logic hold_low_reg, fast_prev_reg, slow_prev_reg, divout_reg;
  logic ext_prev_reg, use_int_reg, ext_ready_next;
  logic [1:0] div_reg;
  logic [8:0] cnt_reg;
  logic [1:0] sync_cnt_reg;
  iocs_state_type state_reg;
  logic [7:0] rdata_reg;
  logic cur_fall, new_rise, new_is_slow, cur_is_slow, new_tick, cur_tick;
  logic fast_want, slow_want;

  // Pin-side ticks pass two flops before any logic looks at them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_sync_reg <= 2'b00;
      slow_sync_reg <= 2'b00;
      ext_sync_reg <= 2'b00;
      ostd_sync_reg <= 2'b00;
      fail_sync_reg <= 2'b00;
    end else begin
      fast_sync_reg <= {fast_sync_reg[0], fast_clk_tick};
      slow_sync_reg <= {slow_sync_reg[0], slow_clk_tick};
      ext_sync_reg <= {ext_sync_reg[0], ext_clk_tick};
      ostd_sync_reg <= {ostd_sync_reg[0], osc_startup_done};
      fail_sync_reg <= {fail_sync_reg[0], clock_fail_active};
    end
  end

  // Register writes; the trim only drives the fast oscillator port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_reg <= TRIM_RESET;
      fsel_reg <= FSEL_RESET;
      scs_reg <= 1'b0;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_TRIM) begin
        trim_reg <= bus.wdata[4:0];
      end else if (bus.addr == ADDR_CTRL) begin
        fsel_reg <= bus.wdata[CTRL_FSEL_LSB +: 3];
        scs_reg <= bus.wdata[CTRL_SCS_BIT];
      end
    end
  end
  // Trim is passed straight to the analog slew; no completion is tracked.
  // Automatic switch-overs read scs_reg but never write it.

  assign new_is_slow = (fsel_reg == FSEL_SLOW);
  assign cur_is_slow = (active_reg == FSEL_SLOW);
  assign new_tick = new_is_slow ? slow_sync_reg[1] : fast_sync_reg[1];
  assign cur_tick = cur_is_slow ? slow_sync_reg[1] : fast_sync_reg[1];
  assign cur_fall = cur_is_slow ? (slow_prev_reg & ~slow_sync_reg[1])
                                : (fast_prev_reg & ~fast_sync_reg[1]);
  assign new_rise = new_is_slow ? (~slow_prev_reg & slow_sync_reg[1])
                                : (~fast_prev_reg & fast_sync_reg[1]);
  assign fast_want = (fsel_reg != FSEL_SLOW) && (scs_reg || two_speed_enable);
  assign slow_want = (new_is_slow && (scs_reg || two_speed_enable)) || power_up_timer_en
    || watchdog_timer_en || clock_fail_monitor_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_prev_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      fast_prev_reg <= fast_sync_reg[1];
      slow_prev_reg <= slow_sync_reg[1];
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  // Switch sequencer. The old source stays enabled until the swap so the
  // system clock never loses its edge source mid-switch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      active_reg <= FSEL_RESET;
      cnt_reg <= '0;
      sync_cnt_reg <= '0;
      hold_low_reg <= 1'b0;
      fast_en_reg <= 1'b1;
      slow_en_reg <= 1'b0;
      fast_ok_reg <= 1'b0;
      slow_ok_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          fast_en_reg <= fast_want | ~cur_is_slow;
          slow_en_reg <= slow_want | cur_is_slow;
          if (fsel_reg != active_reg) begin
            if (!cur_is_slow && !new_is_slow) begin
              state_reg <= ST_SWAP;
            end else if (new_is_slow ? slow_ok_reg : fast_ok_reg) begin
              state_reg <= ST_SYNC;
              sync_cnt_reg <= '0;
            end else begin
              state_reg <= ST_START;
              cnt_reg <= new_is_slow ? 9'(SLOW_START_CYC) : 9'(FAST_START_CYC);
              if (new_is_slow) begin
                slow_en_reg <= 1'b1;
              end else begin
                fast_en_reg <= 1'b1;
              end
            end
          end
        end
        ST_START: begin
          if (cnt_reg <= 9'd1) begin
            state_reg <= ST_SYNC;
            sync_cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg - 9'd1;
          end
        end
        ST_SYNC: begin
          if (new_rise) begin
            sync_cnt_reg <= sync_cnt_reg + 2'd1;
            if (sync_cnt_reg == 2'(SYNC_CYC - 1)) begin
              state_reg <= ST_SWAP;
            end
          end
        end
        ST_SWAP: begin
          if (!hold_low_reg && (cur_fall || !cur_tick)) begin
            hold_low_reg <= 1'b1;
          end else if (hold_low_reg && new_rise) begin
            hold_low_reg <= 1'b0;
            active_reg <= fsel_reg;
            state_reg <= ST_IDLE;
            fast_ok_reg <= !new_is_slow;
            slow_ok_reg <= new_is_slow || slow_want;
            if (!new_is_slow && !watchdog_timer_en && !clock_fail_monitor_en
                && !power_up_timer_en) begin
              slow_en_reg <= 1'b0;
            end
            if (new_is_slow && !fast_want) begin
              fast_en_reg <= 1'b0;
            end
          end
        end
      endcase
      if (state_reg == ST_IDLE && slow_en_reg && slow_rise_seen()) begin
        slow_ok_reg <= 1'b1;
      end
      if (state_reg == ST_IDLE && fast_en_reg && !cur_is_slow) begin
        fast_ok_reg <= 1'b1;
      end
    end
  end

  function automatic logic slow_rise_seen();
    return ~slow_prev_reg & slow_sync_reg[1];
  endfunction

  // Source choice: external with select bit 0 and no fail; in crystal mode only once its start-up timer is done.
  assign ext_ready_next = !scs_reg && !fail_sync_reg[1]
    && (!ext_crystal_mode || ostd_sync_reg[1]);

  // The inverse is kept in its own flop so the output needs no gate after it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ready_reg <= 1'b0;
      use_int_reg <= 1'b1;
    end else begin
      ext_ready_reg <= ext_ready_next;
      use_int_reg <= !ext_ready_next;
    end
  end

  // Divide-by-4 output of the running system clock, held low during a swap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 2'b00;
      divout_reg <= 1'b0;
    end else begin
      if (ext_ready_reg ? (~ext_prev_reg & ext_sync_reg[1]) : new_tick_edge()) begin
        div_reg <= div_reg + 2'd1;
      end
      divout_reg <= !hold_low_reg && div_reg[1];
    end
  end

  function automatic logic new_tick_edge();
    return cur_is_slow ? (~slow_prev_reg & slow_sync_reg[1])
                       : (~fast_prev_reg & fast_sync_reg[1]);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_TRIM: rdata_reg <= {3'b000, trim_reg};
        ADDR_CTRL: rdata_reg <= {1'b0, fsel_reg, ext_ready_reg, fast_ok_reg,
                                 slow_ok_reg, scs_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign trim_value = trim_reg;
  assign fast_osc_enable = fast_en_reg;
  assign slow_osc_enable = slow_en_reg;
  assign active_freq_select = active_reg;
  assign use_internal = use_int_reg;
  assign sys_clk_gate_low = hold_low_reg;
  assign divided_clock_output = divout_reg;
endmodule

// ===== test/iocs_asserts.sv
`timescale 1ns/1ps
module iocs_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input iocs_pkg::iocs_bus_type bus,
  input wire logic [7:0] rdata,
  input wire logic [4:0] trim_value,
  input wire logic slow_osc_enable,
  input wire logic use_internal,
  input wire logic sys_clk_gate_low,
  input wire logic power_up_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic clock_fail_monitor_en
);
  import iocs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tw;
  logic cw;
  logic cr;
  logic [4:0] wt;
  logic [2:0] ws;
  assign tw = bus.wr && bus.addr == ADDR_TRIM;
  assign cw = bus.wr && bus.addr == ADDR_CTRL;
  assign cr = bus.rd && bus.addr == ADDR_CTRL;
  assign wt = bus.wdata[4:0];
  assign ws = bus.wdata[CTRL_FSEL_LSB +: 3];
  a_trim_upper_zero: assert property (bus.rd && bus.addr == ADDR_TRIM |=> rdata[7:5] == 3'h0)
    else $error("trim upper bits not zero");
  a_trim_write_load: assert property (tw |=> trim_value == $past(wt))
    else $error("trim write not taken");
  a_trim_hold: assert property (!tw |=> $stable(trim_value))
    else $error("trim changed without write");
  a_ctrl_read_scs: assert property (cw ##1 !bus.wr ##1 cr |=> rdata[0] == $past(bus.wdata[0], 3))
    else $error("select bit readback wrong");
  a_ctrl_read_sel: assert property (cw ##1 !bus.wr ##1 cr |=> rdata[6:4] == $past(ws, 3))
    else $error("frequency select readback wrong");
  a_internal_on_scs: assert property (cw && bus.wdata[0] |-> ##[1:8] use_internal)
    else $error("internal source not used");
  a_gate_low_bounded: assert property ($rose(sys_clk_gate_low) |-> ##[1:100] !sys_clk_gate_low)
    else $error("clock held low too long");
  a_slow_on_timers: assert property
    ((power_up_timer_en || watchdog_timer_en || clock_fail_monitor_en) [*4] |-> slow_osc_enable)
    else $error("slow oscillator off with timer on");
endmodule
bind iocs_clock_select iocs_asserts u_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .trim_value(trim_value), .slow_osc_enable(slow_osc_enable), .use_internal(use_internal),
  .sys_clk_gate_low(sys_clk_gate_low), .power_up_timer_en(power_up_timer_en),
  .watchdog_timer_en(watchdog_timer_en), .clock_fail_monitor_en(clock_fail_monitor_en));

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import iocs_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] e;} iocs_row_type;
  iocs_row_type rows [6] = '{'{ADDR_TRIM, 8'h0F, 8'h0F}, '{ADDR_TRIM, 8'h10, 8'h10},
    '{ADDR_TRIM, 8'hFF, 8'h1F}, '{ADDR_TRIM, 8'hE0, 8'h00}, '{4'h2, 8'hFF, 8'h00},
    '{4'hF, 8'hA5, 8'h00}};
  logic clk = 0;
  logic rst_n = 0;
  iocs_bus_type bus = '0;
  logic [7:0] tk = '0;
  logic crys = 1;
  logic done = 0;
  logic wdt = 0;
  logic fail_act = 0;
  logic [7:0] rdata;
  logic [4:0] trim_value;
  logic fast_en;
  logic slow_en;
  logic [2:0] active_freq_select;
  logic use_internal;
  logic gate;
  logic divout;
  logic gate_seen = 0;
  logic div_seen = 0;
  logic [7:0] d;
  logic [4:0] t = '0;
  int n;
  int fails = 0;
  int cmp_count = 0;
  iocs_clock_select uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .fast_clk_tick(tk[2]), .slow_clk_tick(tk[4]), .ext_clk_tick(tk[3]),
    .two_speed_enable(1'b0), .ext_crystal_mode(crys), .osc_startup_done(done),
    .power_up_timer_en(1'b0), .watchdog_timer_en(wdt), .clock_fail_monitor_en(1'b0),
    .clock_fail_active(fail_act), .trim_value(trim_value), .fast_osc_enable(fast_en),
    .slow_osc_enable(slow_en), .active_freq_select(active_freq_select),
    .use_internal(use_internal), .sys_clk_gate_low(gate), .divided_clock_output(divout));
  always @(posedge clk) begin
    if (gate === 1'b1) gate_seen <= 1'b1;
    if (divout === 1'b1) div_seen <= 1'b1;
  end
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Oscillator levels come from a free counter so their edges are slow enough to sync.
  always @(posedge clk) tk <= tk + 8'h01;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge clk);
    bus <= {a, w, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_sel(input logic [2:0] s, output int c);
    c = 0;
    while (active_freq_select !== s && c < 2000) begin
      @(posedge clk);
      c++;
    end
    chk({5'h00, active_freq_select}, {5'h00, s}, "switch");
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #60000 fails++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_TRIM, d);
    chk(d, 8'h00, "trim reset");
    rd(ADDR_CTRL, d);
    chk(d & 8'h71, 8'h60, "ctrl reset");
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk(d, rows[i].e, "readback");
      if (rows[i].a == ADDR_TRIM) t = rows[i].e[4:0];
      chk({3'h0, trim_value}, {3'h0, t}, "trim out");
    end
    $display("table test done");
    repeat (8) @(posedge clk);
    chk({7'h00, use_internal}, 8'h01, "crystal not ready");
    done <= 1'b1;
    repeat (8) @(posedge clk);
    chk({7'h00, use_internal}, 8'h00, "external ready");
    wr(ADDR_CTRL, 8'h61);
    repeat (8) @(posedge clk);
    chk({7'h00, use_internal}, 8'h01, "internal chosen");
    fail_act <= 1'b1;
    rd(ADDR_CTRL, d);
    chk(d & 8'h01, 8'h01, "select bit kept");
    fail_act <= 1'b0;
    $display("source test done");
    wr(ADDR_CTRL, 8'h01);
    wait_sel(3'h0, n);
    rd(ADDR_CTRL, d);
    chk(d & 8'h02, 8'h02, "slow stable");
    chk({7'h00, slow_en}, 8'h01, "slow enable");
    wr(ADDR_CTRL, 8'h71);
    wait_sel(3'h7, n);
    chk({7'h00, n >= FAST_START_CYC - 2}, 8'h01, "fast start delay");
    rd(ADDR_CTRL, d);
    chk(d & 8'h04, 8'h04, "fast stable");
    chk({7'h00, fast_en}, 8'h01, "fast enable");
    repeat (8) @(posedge clk);
    chk({7'h00, slow_en}, 8'h00, "slow off");
    wr(ADDR_CTRL, 8'h11);
    wait_sel(3'h1, n);
    chk({7'h00, n < FAST_START_CYC}, 8'h01, "tap switch quick");
    wdt <= 1'b1;
    repeat (8) @(posedge clk);
    chk({7'h00, slow_en}, 8'h01, "slow for timer");
    chk({7'h00, gate_seen}, 8'h01, "clock held low in switch");
    chk({7'h00, div_seen}, 8'h01, "divided clock runs");
    $display("switch test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({5'h00, active_freq_select}, 8'h06, "select after reset");
    rd(ADDR_CTRL, d);
    chk(d & 8'h71, 8'h60, "ctrl after reset");
    $display("second reset test done");
    finish_test;
  end
endmodule
